// ### bench/tb_dsoc_ctrl.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ns
`default_nettype none

module tb_dsoc_ctrl import dsoc_pkg::*;;
  // ==========================================================
  // Settings and signals
  localparam logic [25:0] START = 26'h0000010; // Short start-up for sim
  localparam int          LIMIT = 20000;       // Hang ceiling in cycles
  logic        sys_clk;        // System clock
  logic        rst_n;          // Reset, active low
  logic [3:0]  reg_addr;       // Register address
  logic [15:0] reg_wdata;      // Write data
  logic        reg_wr;         // Write strobe
  logic        reg_rd;         // Read strobe
  logic [15:0] reg_rdata;      // Read data
  logic        sleep_mode;     // Device sleeping
  logic        rtc_clk_req;    // Clock unit request
  logic        timer_clk_req;  // Timer unit request
  logic        tosc_run;       // Tunable osc runs
  logic [4:0]  tosc_freq_mhz;  // Decoded frequency
  logic        tosc_code_ok;   // Code not reserved
  logic        sosc_enable;    // Secondary osc on
  logic        sosc_clk_valid; // Secondary clock usable
  logic        pins_digital;   // Pins freed to digital
  int          bad_count;      // Mismatches
  int          n_tests;        // Comparisons
  int          cyc;            // Cycle counter for the hang limit
  logic [31:0] seed;           // Xorshift state

  dsoc_ctrl #(.START_CYC(START)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .rtc_clk_req(rtc_clk_req), .timer_clk_req(timer_clk_req),
    .tosc_run(tosc_run), .tosc_freq_mhz(tosc_freq_mhz),
    .tosc_code_ok(tosc_code_ok), .sosc_enable(sosc_enable),
    .sosc_clk_valid(sosc_clk_valid), .pins_digital(pins_digital));

  // ==========================================================
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // A stuck wait loop must still reach the verdict
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected MHz for a code; reserved codes give zero
  function automatic logic [4:0] exp_mhz(input logic [3:0] c);
    if (c <= 4'h7) return {1'b0, c} + 5'h01;
    if (c == 4'hE) return 5'h0F;
    if (c == 4'hF) return 5'h1E;
    return 5'h00;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Data is sampled in the one cycle where it stands
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Source 0 clock unit, 1 timer unit, 2 manual bit
  task automatic src(input int s, input logic on);
    if (s == 2) begin
      wr(DSOC_SOSC_OFF, {15'h0000, on});
    end else begin
      @(posedge sys_clk);
      if (s == 0) rtc_clk_req <= on;
      else timer_clk_req <= on;
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin : main
    logic [15:0] d;
    logic [15:0] w;
    logic [31:0] r;
    int          n;
    logic        e;
    rst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; sleep_mode = 1'b0;
    rtc_clk_req = 1'b0; timer_clk_req = 1'b0;
    bad_count = 0; n_tests = 0; cyc = 0; seed = 32'd29131;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, idle read data and unmapped places
    rd(DSOC_TOSC_OFF, d); chk("tosc reset", d, DSOC_TOSC_RST);
    rd(DSOC_SOSC_OFF, d); chk("sosc reset", d, DSOC_SOSC_RST);
    rd(DSOC_CFG_OFF, d); chk("cfg reset", d, DSOC_CFG_RST);
    step(1); chk("rdata idle", reg_rdata, 16'h0000);
    wr(4'h5, 16'hFFFF);
    rd(4'h9, d); chk("unmapped rd", d, 16'h0000);
    rd(DSOC_TOSC_OFF, d); chk("unmapped wr", d, DSOC_TOSC_RST);
    // Every code, with each keep and sleep pairing; junk in free bits
    for (int c = 0; c < 16; c++) begin
      r = xs();
      @(posedge sys_clk);
      sleep_mode <= c[0];
      w = (r[15:0] & ~DSOC_TOSC_MSK) | {2'b00, c[1], 1'b0, c[3:0], 8'h00};
      wr(DSOC_TOSC_OFF, w);
      step(2);
      chk("freq", 16'(tosc_freq_mhz), 16'(exp_mhz(c[3:0])));
      chk("code ok", 16'(tosc_code_ok), 16'(c < 8 || c > 13));
      chk("tosc run", 16'(tosc_run), 16'(!c[0] || c[1]));
      rd(DSOC_TOSC_OFF, d); chk("tosc rb", d, w & DSOC_TOSC_MSK);
    end
    // Start-up timing from each requester, then shutdown order
    for (int s = 0; s < 3; s++) begin
      src(s, 1'b1);
      step(1); chk("enable on", 16'(sosc_enable), 16'h0001);
      n = 0;
      while (sosc_clk_valid !== 1'b1 && n < 100) begin
        step(1);
        n = n + 1;
      end
      // Done lands START edges after the enable flop rises
      chk("valid delay", 16'(n), 16'(START));
      src(s, 1'b0);
      step(1); chk("enable off", 16'(sosc_enable), 16'h0000);
      chk("valid hold", 16'(sosc_clk_valid), 16'h0001);
      step(1); chk("valid off", 16'(sosc_clk_valid), 16'h0000);
    end
    // Pins given to digital: requests are refused
    wr(DSOC_CFG_OFF, 16'h0000);
    step(1); chk("pins dig", 16'(pins_digital), 16'h0001);
    src(1, 1'b1);
    src(2, 1'b1);
    step(3); chk("gated en", 16'(sosc_enable), 16'h0000);
    step(20); chk("gated val", 16'(sosc_clk_valid), 16'h0000);
    src(1, 1'b0);
    src(2, 1'b0);
    // Random mix of manual bit, pin bit and both requests
    for (int i = 0; i < 40; i++) begin
      r = xs();
      wr(DSOC_SOSC_OFF, r[15:0]);
      wr(DSOC_CFG_OFF, r[31:16]);
      @(posedge sys_clk);
      rtc_clk_req   <= r[5];
      timer_clk_req <= r[6];
      step(2);
      e = r[19] & (r[0] | r[5] | r[6]);
      chk("enable mix", 16'(sosc_enable), 16'(e));
      chk("pins mix", 16'(pins_digital), 16'(!r[19]));
      rd(DSOC_STAT_OFF, d);
      // Valid depends on history, so it is masked out here
      chk("status", d & 16'h1F1D,
          {3'b000, 5'h1E, 3'b000, 1'b1, 1'b1, !r[19], 1'b0, e});
      rd(DSOC_SOSC_OFF, d); chk("sosc rb", d, r[15:0] & DSOC_SOSC_MSK);
      rd(DSOC_CFG_OFF, d); chk("cfg rb", d, r[31:16] & DSOC_CFG_MSK);
    end
    // Mid-run reset; inputs go quiet first so that no check that
    // starts on the release edge sees a request or sleep
    @(posedge sys_clk);
    sleep_mode    <= 1'b0;
    rtc_clk_req   <= 1'b0;
    timer_clk_req <= 1'b0;
    rst_n         <= 1'b0;
    step(2);
    chk("rst en", 16'(sosc_enable), 16'h0000);
    chk("rst valid", 16'(sosc_clk_valid), 16'h0000);
    chk("rst run", 16'(tosc_run), 16'h0001);
    chk("rst freq", 16'(tosc_freq_mhz), 16'(exp_mhz(4'h7)));
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(DSOC_TOSC_OFF, d); chk("tosc rst", d, DSOC_TOSC_RST);
    rd(DSOC_CFG_OFF, d); chk("cfg rst", d, DSOC_CFG_RST);
    report_and_stop();
  end

endmodule // tb_dsoc_ctrl

`default_nettype wire

// ### design/dsoc_ctrl.sv
// Tunable and secondary oscillator control with register port
`timescale 1ns/1ns
`default_nettype none

module dsoc_ctrl import dsoc_pkg::*; #(
  parameter logic [25:0] START_CYC = 26'(DSOC_START_CYC) // Start-up wait
) (
  input  wire logic        sys_clk,        // System clock, 50 MHz
  input  wire logic        rst_n,          // Async reset, active low
  input  wire logic [3:0]  reg_addr,       // Register address
  input  wire logic [15:0] reg_wdata,      // Register write data
  input  wire logic        reg_wr,         // Write strobe
  input  wire logic        reg_rd,         // Read strobe
  output logic      [15:0] reg_rdata,      // Read data, next cycle
  input  wire logic        sleep_mode,     // Device is in sleep
  input  wire logic        rtc_clk_req,    // Real-time clock unit request
  input  wire logic        timer_clk_req,  // First timer unit request
  output logic             tosc_run,       // Tunable oscillator runs
  output logic      [4:0]  tosc_freq_mhz,  // Tunable frequency in MHz
  output logic             tosc_code_ok,   // Frequency code not reserved
  output logic             sosc_enable,    // Secondary oscillator on
  output logic             sosc_clk_valid, // Secondary clock usable
  output logic             pins_digital    // Osc pins serve digital I/O
);

  // ==========================================================
  // Declarations
  dsoc_if      link ();                  // Helper carrier
  logic [15:0] tosc_ctrl_reg;            // tunable_osc_control
  logic [15:0] sosc_ctrl_reg;            // Manual start register
  logic [15:0] osc_cfg_reg;              // oscillator_config_word
  logic        tunable_osc_sleep_keep;   // Keep running in sleep
  logic        secondary_osc_manual_on;  // Manual start
  logic        secondary_osc_pin_function; // Pins serve oscillator
  logic        any_req;                  // Some peripheral wants clock
  logic        sosc_enable_next;         // Next enable value
  logic        tosc_run_reg;             // Tunable run flop
  logic        sosc_enable_reg;          // Secondary enable flop
  logic        pins_digital_reg;         // Pin mode flop
  logic [15:0] rdata_reg;                // Read data flop
  logic [15:0] rdata_next;               // Read data mux
  logic [15:0] status_word;              // Live status view
  dsoc_state_t state_reg;                // Secondary osc state
  dsoc_state_t state_next;               // Next state

  // ==========================================================
  // Field views
  assign tunable_osc_sleep_keep     = tosc_ctrl_reg[DSOC_KEEP_BIT];
  assign secondary_osc_manual_on    = sosc_ctrl_reg[DSOC_MAN_BIT];
  assign secondary_osc_pin_function = osc_cfg_reg[DSOC_PIN_BIT];
  assign any_req                    = rtc_clk_req | timer_clk_req;

  // ==========================================================
  // Register writes; unimplemented bits are dropped on entry
  // Reserved frequency codes are stored as written; the decoder
  // flags them so software can see the mistake.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tosc_ctrl_reg <= DSOC_TOSC_RST;
      sosc_ctrl_reg <= DSOC_SOSC_RST;
      osc_cfg_reg   <= DSOC_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == DSOC_TOSC_OFF) begin
        tosc_ctrl_reg <= reg_wdata & DSOC_TOSC_MSK;
      end else if (reg_addr == DSOC_SOSC_OFF) begin
        sosc_ctrl_reg <= reg_wdata & DSOC_SOSC_MSK;
      end else if (reg_addr == DSOC_CFG_OFF) begin
        osc_cfg_reg   <= reg_wdata & DSOC_CFG_MSK;
      end
    end
  end

  // ==========================================================
  // Status word: live state of both oscillators
  always_comb begin
    status_word       = 16'h0000;
    status_word[0]    = sosc_enable_reg;
    status_word[1]    = link.tmr_done;
    status_word[2]    = pins_digital_reg;
    status_word[3]    = tosc_run_reg;
    status_word[4]    = link.code_ok;
    status_word[12:8] = link.freq_mhz;
  end

  // ==========================================================
  // Read mux; unmapped addresses read as zero
  always_comb begin
    if (reg_addr == DSOC_TOSC_OFF) begin
      rdata_next = tosc_ctrl_reg;
    end else if (reg_addr == DSOC_SOSC_OFF) begin
      rdata_next = sosc_ctrl_reg;
    end else if (reg_addr == DSOC_CFG_OFF) begin
      rdata_next = osc_cfg_reg;
    end else if (reg_addr == DSOC_STAT_OFF) begin
      rdata_next = status_word;
    end else begin
      rdata_next = 16'h0000;
    end
  end

  // ==========================================================
  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // ==========================================================
  // Tunable oscillator sleep behaviour
  // sleep keep or stop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tosc_run_reg <= 1'b1;
    end else begin
      tosc_run_reg <= !sleep_mode || tunable_osc_sleep_keep;
    end
  end

  // ==========================================================
  // Secondary oscillator enable
  // gated OR of sources
  assign sosc_enable_next = secondary_osc_pin_function
                            && (secondary_osc_manual_on || any_req);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sosc_enable_reg <= 1'b0;
    end else begin
      sosc_enable_reg <= sosc_enable_next;
    end
  end

  // ==========================================================
  // Pin function; digital whenever the oscillator owns no pins
  // release pins to digital
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_digital_reg <= 1'b0;
    end else begin
      pins_digital_reg <= !secondary_osc_pin_function;
    end
  end

  // ==========================================================
  // Secondary oscillator state; tracks the start-up wait
  // valid after start-up
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DSOC_OFF: begin
        // Leave only once the enable flop has risen
        if (sosc_enable_reg) begin
          state_next = DSOC_START;
        end
      end
      DSOC_START: begin
        if (!sosc_enable_reg) begin
          state_next = DSOC_OFF;
        end else if (link.tmr_done) begin
          state_next = DSOC_RUN;
        end
      end
      DSOC_RUN: begin
        // A stop loses the clock; a restart waits again
        if (!sosc_enable_reg) begin
          state_next = DSOC_OFF;
        end
      end
      default: begin
        state_next = DSOC_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DSOC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Helpers
  assign link.freq_code = tosc_ctrl_reg[DSOC_FSEL_MSB:DSOC_FSEL_LSB];
  assign link.tmr_run   = sosc_enable_reg;

  dsoc_freq_dec u_dec (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (link)
  );

  dsoc_start_tmr #(
    .LIMIT (START_CYC)
  ) u_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (link)
  );

  // ==========================================================
  // Outputs, each from a flop
  assign reg_rdata      = rdata_reg;
  assign tosc_run       = tosc_run_reg;
  assign tosc_freq_mhz  = link.freq_mhz;
  assign tosc_code_ok   = link.code_ok;
  assign sosc_enable    = sosc_enable_reg;
  assign sosc_clk_valid = link.tmr_done;
  assign pins_digital   = pins_digital_reg;

  // ==========================================================
  // Checks
  // stop in sleep
  chk_sleep_stop: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    sleep_mode && !tunable_osc_sleep_keep |=> !tosc_run)
    else $error("Tunable osc ran in sleep without keep");
  chk_sleep_keep: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    tunable_osc_sleep_keep |=> tosc_run)
    else $error("Tunable osc stopped despite keep");
  chk_auto_start: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secondary_osc_pin_function && any_req |=> sosc_enable)
    else $error("Peripheral request did not start osc");
  chk_manual_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secondary_osc_pin_function && secondary_osc_manual_on
      |=> sosc_enable)
    else $error("Manual start did not run osc");
  chk_pin_gate: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !secondary_osc_pin_function |=> !sosc_enable)
    else $error("Osc ran with pins in digital mode");
  chk_no_source: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !any_req && !secondary_osc_manual_on |=> !sosc_enable)
    else $error("Osc enabled with no source");
  chk_pins_dig: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !secondary_osc_pin_function |=> pins_digital ##0 !sosc_enable)
    else $error("Pins not released to digital");
  chk_pins_osc: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secondary_osc_pin_function |=> !pins_digital)
    else $error("Pins left digital while osc owns them");
  chk_valid_wait: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    $rose(sosc_enable) |-> !sosc_clk_valid [*2])
    else $error("Clock valid too early");
  chk_valid_en: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    sosc_clk_valid |-> $past(sosc_enable))
    else $error("Clock valid while osc off");
  // a stop drops valid; the timer restarts from zero
  chk_valid_drop: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !sosc_enable |=> !sosc_clk_valid)
    else $error("Clock valid outlived the enable");
  // reserved codes flagged, so software can spot misuse
  chk_code_flag: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    link.freq_code > DSOC_CODE_MAX && link.freq_code < DSOC_CODE_15
      |=> !tosc_code_ok)
    else $error("Reserved code not flagged");
  chk_read_late: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    reg_rd && reg_addr == DSOC_TOSC_OFF |=>
      reg_rdata == $past(tosc_ctrl_reg))
    else $error("Read data wrong or late");

  cov_valid:  cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(sosc_clk_valid));
  cov_keep:   cover property (@(posedge sys_clk) disable iff (!rst_n)
    sleep_mode && tosc_run);
  cov_manual: cover property (@(posedge sys_clk) disable iff (!rst_n)
    secondary_osc_manual_on && !any_req && sosc_enable);
  cov_digital: cover property (@(posedge sys_clk) disable iff (!rst_n)
    pins_digital && any_req);

endmodule // dsoc_ctrl

`default_nettype wire

// ### design/dsoc_freq_dec.sv
// Frequency select decoder for the tunable oscillator
`timescale 1ns/1ns
`default_nettype none

module dsoc_freq_dec import dsoc_pkg::*; (
  input  wire logic sys_clk,  // System clock
  input  wire logic rst_n,    // Asynchronous reset, active low
  dsoc_if.dec       bus       // Code in, frequency out
);

  // ==========================================================
  // Registered decode; reserved codes read as 0 MHz, not ok
  // code to frequency table
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.freq_mhz <= 5'h08;
      bus.code_ok  <= 1'b1;
    end else if (bus.freq_code <= DSOC_CODE_MAX) begin
      // Stepped range, one MHz per code
      bus.freq_mhz <= {1'b0, bus.freq_code} + 5'h01;
      bus.code_ok  <= 1'b1;
    end else if (bus.freq_code == DSOC_CODE_15) begin
      bus.freq_mhz <= DSOC_MHZ_15;
      bus.code_ok  <= 1'b1;
    end else if (bus.freq_code == DSOC_CODE_30) begin
      bus.freq_mhz <= DSOC_MHZ_30;
      bus.code_ok  <= 1'b1;
    end else begin
      // Reserved code: no valid frequency
      bus.freq_mhz <= 5'h00;
      bus.code_ok  <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  // top code decode
  chk_code_thirty: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    bus.freq_code == DSOC_CODE_30 |=> bus.freq_mhz == DSOC_MHZ_30)
    else $error("30 MHz code decoded wrong");
  chk_code_step: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    bus.freq_code <= DSOC_CODE_MAX |=>
      bus.freq_mhz == {1'b0, $past(bus.freq_code)} + 5'h01)
    else $error("Stepped code decoded wrong");

endmodule // dsoc_freq_dec

`default_nettype wire

// ### design/dsoc_if.sv
// Internal carrier between the control core and its helpers
`timescale 1ns/1ns
`default_nettype none

interface dsoc_if;
  logic [3:0] freq_code;  // Frequency select code
  logic [4:0] freq_mhz;   // Decoded frequency in MHz
  logic       code_ok;    // Code is not reserved
  logic       tmr_run;    // Start-up timer runs
  logic       tmr_done;   // Start-up time elapsed

  modport core (output freq_code, output tmr_run,
                input freq_mhz, input code_ok, input tmr_done);
  modport dec  (input freq_code, output freq_mhz, output code_ok);
  modport tmr  (input tmr_run, output tmr_done);
endinterface

`default_nettype wire

// ### design/dsoc_pkg.sv
// Constants shared by the oscillator control block and its helpers
package dsoc_pkg;

  // ==========================================================
  // Register port geometry
  localparam int          DSOC_ADDR_W   = 4;   // Register address width
  localparam int          DSOC_DATA_W   = 16;  // Register data width

  // ==========================================================
  // Register offsets
  localparam logic [3:0]  DSOC_TOSC_OFF = 4'h0; // tunable_osc_control
  localparam logic [3:0]  DSOC_SOSC_OFF = 4'h1; // Secondary osc control
  localparam logic [3:0]  DSOC_CFG_OFF  = 4'h2; // oscillator_config_word
  localparam logic [3:0]  DSOC_STAT_OFF = 4'h3; // Status, read only

  // ==========================================================
  // Field positions and masks
  localparam int          DSOC_KEEP_BIT = 13;  // Sleep-keep bit
  localparam int          DSOC_FSEL_LSB = 8;   // Frequency select low bit
  localparam int          DSOC_FSEL_MSB = 11;  // Frequency select high bit
  localparam int          DSOC_MAN_BIT  = 0;   // Manual start bit
  localparam int          DSOC_PIN_BIT  = 3;   // Pin function bit
  localparam logic [15:0] DSOC_TOSC_MSK = 16'h2F00; // Implemented bits
  localparam logic [15:0] DSOC_SOSC_MSK = 16'h0001; // Implemented bits
  localparam logic [15:0] DSOC_CFG_MSK  = 16'h0008; // Implemented bits

  // ==========================================================
  // Reset values
  localparam logic [15:0] DSOC_TOSC_RST = 16'h0700; // 8 MHz, no keep
  localparam logic [15:0] DSOC_SOSC_RST = 16'h0000; // Manual start off
  localparam logic [15:0] DSOC_CFG_RST  = 16'h0008; // Pins serve osc

  // ==========================================================
  // Frequency decode constants
  localparam logic [3:0]  DSOC_CODE_MAX = 4'h7;  // Last stepped code
  localparam logic [3:0]  DSOC_CODE_15  = 4'hE;  // 15 MHz code
  localparam logic [3:0]  DSOC_CODE_30  = 4'hF;  // 30 MHz code
  localparam logic [4:0]  DSOC_MHZ_15   = 5'h0F; // 15 MHz
  localparam logic [4:0]  DSOC_MHZ_30   = 5'h1E; // 30 MHz

  // ==========================================================
  // Timing
  localparam int          DSOC_CLK_MHZ  = 50;    // System clock rate
  localparam int          DSOC_START_MS = 1000;  // Start-up time, 1 second
  localparam int          DSOC_START_CYC = DSOC_START_MS * DSOC_CLK_MHZ
                                           * 1000; // Start-up in cycles
  localparam int          DSOC_CNT_W    = 26;    // Start-up counter width

  // ==========================================================
  // Secondary oscillator states
  typedef enum logic [1:0] {
    DSOC_OFF   = 2'b00,  // Oscillator stopped
    DSOC_START = 2'b01,  // Waiting out the start-up time
    DSOC_RUN   = 2'b10   // Clock valid
  } dsoc_state_t;

endpackage

// ### design/dsoc_start_tmr.sv
// Start-up interval timer for the secondary oscillator
`timescale 1ns/1ns
`default_nettype none

module dsoc_start_tmr import dsoc_pkg::*; #(
  parameter logic [25:0] LIMIT = 26'd50000000  // Cycles to wait
) (
  input  wire logic sys_clk,  // System clock
  input  wire logic rst_n,    // Asynchronous reset, active low
  dsoc_if.tmr       bus       // Run in, done out
);

  logic [DSOC_CNT_W-1:0] cnt_reg;  // Elapsed cycles while running

  // ==========================================================
  // Count while running; any stop restarts the full wait
  // start-up interval count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      bus.tmr_done <= 1'b0;
    end else if (!bus.tmr_run) begin
      cnt_reg  <= '0;
      bus.tmr_done <= 1'b0;
    end else if (cnt_reg >= LIMIT - 26'd1) begin
      // Hold done until the oscillator is stopped
      bus.tmr_done <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 26'd1;
    end
  end

  // ==========================================================
  // Checks
  // done needs run
  chk_done_run: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    bus.tmr_done |-> $past(bus.tmr_run))
    else $error("Timer done without running");

endmodule // dsoc_start_tmr

`default_nettype wire
